// file: core/cdms_params.svh
// register offsets, field positions and reset values of the multiplier slice
`ifndef CDMS_PARAMS_SVH
`define CDMS_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CDMS_OFS_CTRL    4'h0
`define CDMS_OFS_STATUS  4'h4

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CDMS_F_MODE      0
`define CDMS_F_PART      2
`define CDMS_F_SIGN_A    4
`define CDMS_F_SIGN_B    5
`define CDMS_F_IN_REG    6
`define CDMS_F_PIPE_REG  7
`define CDMS_F_OUT_REG   8
`define CDMS_F_PREADD    9
`define CDMS_F_SUB       10
`define CDMS_F_SAT       11
`define CDMS_F_RND       12
`define CDMS_F_RSH       16
`define CDMS_CTRL_MASK   32'h001f_1fff
`define CDMS_CTRL_RESET  32'h0000_01c0

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define CDMS_F_CNT       0
`define CDMS_F_FULL      8
`define CDMS_F_EMPTY     9
`define CDMS_F_SAT_HIT   16

`endif

// file: core/cdms_pkg.sv
// types shared by the multiplier slice files
package cdms_pkg;

  // ----------------------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_multiply,
    mode_multiply_accumulate,
    mode_multiply_add_subtract,
    mode_multiply_add_subtract_sum
  } cdms_mode_t;

  // ----------------------------------------------------------------------------
  // multiplier partitions
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    mul_36_by_36,
    mul_18_by_36,
    mul_18_by_18,
    mul_9_by_9
  } cdms_part_t;

endpackage : cdms_pkg

// file: core/cdms_fifo.sv
// result fifo with registered read data
module cdms_fifo #(
  parameter int WIDTH = 160,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       clk_en,
  input  wire logic                       clr,
  // fill side
  input  wire logic                       in_valid,
  output      logic                       in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // drain side
  output      logic                       out_valid,
  input  wire logic                       out_ready,
  output      logic [WIDTH-1:0]           out_data,
  // fill level
  output      logic [$clog2(DEPTH):0]     count
);

  localparam int PW = $clog2(DEPTH);

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("cdms_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [PW-1:0]    wr_r;          // write pointer
  logic [PW-1:0]    rd_r;          // read pointer
  logic [PW:0]      cnt_r;         // words held
  logic [WIDTH-1:0] dout_r;        // head word
  logic             push;          // word taken
  logic             pop;           // word given

  assign in_ready  = cnt_r != (PW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign push      = clk_en & ~clr & in_valid & in_ready;
  assign pop       = clk_en & ~clr & out_valid & out_ready;
  assign out_data  = dout_r;
  assign count     = cnt_r;

  // storage write, data only
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (clr) begin
        wr_r  <= '0;
        rd_r  <= '0;
        cnt_r <= '0;
      end else begin
        if (push) wr_r <= wr_r + 1'b1;
        if (pop)  rd_r <= rd_r + 1'b1;
        if (push && !pop)      cnt_r <= cnt_r + 1'b1;
        else if (pop && !push) cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // head register: reloaded whenever the head word changes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout_r <= '0;
    end else if (clk_en) begin
      if (clr) begin
        dout_r <= '0;
      end else if (push && (cnt_r == '0 || (pop && cnt_r == 1))) begin
        dout_r <= in_data;                      // bypass into empty head
      end else if (pop && cnt_r > 1) begin
        dout_r <= mem[PW'(rd_r + 1'b1)];        // next stored word
      end
    end
  end

endmodule : cdms_fifo

// file: core/cdms_slice.sv
// configurable multiplier slice with wishbone control and result fifo
//
// What this block does
// - four modes: multiply, accumulate, add/subtract, sum
// - one 36x36, two 18x36, four 18x18, eight 9x9
// - signedness chosen separately for both operands
// - active-high reset acts only on clock edge
// - optional operand and product registers, bypassable
// - optional internal pipeline stage adds one cycle
// - pre-adder sums two operands, multiplies by third
// - pre-adder also works with 9x9 lanes
// - accumulator adds each product to, or subtracts it from, running total
// - product added to or subtracted from operand
// - optional saturation and rounding of results; add/subtract-mode overflow is never clamped
// - registered (a+b)*c fits in one slice
`include "cdms_params.svh"

module cdms_slice #(
  parameter int FIFO_DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           clk_en,
  input  wire logic           rst,
  // wishbone slave
  input  wire logic           wb_cyc,
  input  wire logic           wb_stb,
  input  wire logic           wb_we,
  input  wire logic [3:0]     wb_adr,
  input  wire logic [3:0]     wb_sel,
  input  wire logic [31:0]    wb_dat_w,
  output      logic [31:0]    wb_dat_r,
  output      logic           wb_ack,
  // operand stream
  input  wire logic           in_valid,
  output      logic           in_ready,
  input  wire logic [71:0]    in_a,
  input  wire logic [71:0]    in_b,
  input  wire logic [71:0]    in_c,
  input  wire logic [159:0]   in_d,
  input  wire logic           in_acc_load,
  // result stream
  output      logic           out_valid,
  input  wire logic           out_ready,
  output      logic [159:0]   out_data
);
  import cdms_pkg::*;

  localparam int AW = 72;    // packed operand width
  localparam int RW = 160;   // packed result width
  localparam int NL = 8;     // most lanes

  // refuse fifo depths the status field cannot show
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 8) begin : g_chk
    $error("cdms_slice: FIFO_DEPTH must lie between 2 and 8");
  end

  // ----------------------------------------------------------------------------
  // lane geometry and arithmetic helpers
  // ----------------------------------------------------------------------------
  // lanes per partition
  function automatic int lanes(input cdms_part_t p);
    unique case (p)
      mul_36_by_36: return 1;
      mul_18_by_36: return 2;
      mul_18_by_18: return 4;
      mul_9_by_9:   return 8;
    endcase
  endfunction : lanes

  // first operand lane width
  function automatic int a_w(input cdms_part_t p);
    return (p == mul_36_by_36) ? 36 : (p == mul_9_by_9) ? 9 : 18;
  endfunction : a_w

  // second operand lane width
  function automatic int b_w(input cdms_part_t p);
    return (p == mul_18_by_18) ? 18 : (p == mul_9_by_9) ? 9 : 36;
  endfunction : b_w

  // result slot width: the product plus guard bits
  function automatic int slot_w(input cdms_part_t p);
    return RW / lanes(p);
  endfunction : slot_w

  // ones in the low w bits
  function automatic logic [RW-1:0] lane_mask(input int w);
    return {RW{1'b1}} >> (RW - w);
  endfunction : lane_mask

  // widen one lane operand, signed or zero extended
  function automatic logic signed [37:0] ext(input logic [AW-1:0] v, input int w,
                                             input logic s);
    logic signed [37:0] r;
    r = '0;
    for (int k = 0; k < 38; k++) begin
      r[k] = (k < w) ? v[k] : (s & v[w-1]);
    end
    return r;
  endfunction : ext

  // all lane products, each sign extended into its slot
  function automatic logic [RW-1:0] products(input logic [AW-1:0] a, b, c,
                                              input cdms_part_t p,
                                              input logic sa, sb, pre);
    logic [RW-1:0]      r;
    logic [RW-1:0]      l;
    logic signed [37:0] x;
    logic signed [37:0] y;
    logic signed [75:0] m;
    int                 wa;
    int                 wb;
    int                 ws;
    r  = '0;
    wa = a_w(p);
    wb = b_w(p);
    ws = slot_w(p);
    for (int i = 0; i < NL; i++) begin
      if (i < lanes(p)) begin
        x = ext(a >> (i * wa), wa, sa);
        if (pre) begin
          x = x + ext(b >> (i * wa), wa, sa);
          y = ext(c >> (i * wb), wb, sb);
        end else begin
          y = ext(b >> (i * wb), wb, sb);
        end
        m = 76'(x) * 76'(y);
        l = {{(RW-76){m[75]}}, m} & lane_mask(ws);
        r = r | (l << (i * ws));
      end
    end
    return r;
  endfunction : products

  // lane-wise add or subtract, overflow flags in the top byte
  function automatic logic [RW+7:0] lane_add(input logic [RW-1:0] x, y,
                                              input logic sub, input cdms_part_t p);
    logic [RW-1:0] s;
    logic [7:0]    ov;
    logic          cy;
    logic          nc;
    logic          yb;
    int            ws;
    ws = slot_w(p);
    s  = '0;
    ov = '0;
    cy = 1'b0;
    for (int k = 0; k < RW; k++) begin
      if (k % ws == 0) cy = sub;                   // carry stops at slot edges
      yb   = y[k] ^ sub;
      s[k] = x[k] ^ yb ^ cy;
      nc   = (x[k] & yb) | (cy & (x[k] ^ yb));
      if (k % ws == ws - 1) ov[k / ws] = cy ^ nc;
      cy = nc;
    end
    return {ov, s};
  endfunction : lane_add

  // clamp overflowed slots to their largest magnitude
  function automatic logic [RW-1:0] saturate(input logic [RW-1:0] s,
                                              input logic [7:0] ov, input cdms_part_t p);
    logic [RW-1:0] r;
    int            ws;
    int            msb;
    ws = slot_w(p);
    r  = s;
    for (int k = 0; k < RW; k++) begin
      msb = (k / ws) * ws + ws - 1;
      if (ov[k / ws]) r[k] = (k == msb) ? ~s[msb] : s[msb];
    end
    return r;
  endfunction : saturate

  // half-weight bias, or the mask of dropped bits, per slot
  function automatic logic [RW-1:0] rnd_bits(input logic [4:0] sh, input logic bias,
                                              input cdms_part_t p);
    logic [RW-1:0] r;
    int            ws;
    ws = slot_w(p);
    r  = '0;
    for (int k = 0; k < RW; k++) begin
      r[k] = bias ? (sh != 0 && k % ws == int'(sh) - 1) : (k % ws < int'(sh));
    end
    return r;
  endfunction : rnd_bits

  // sum of all slots as one wide word
  function automatic logic [RW-1:0] lane_total(input logic [RW-1:0] v,
                                                input cdms_part_t p);
    logic [RW-1:0] t;
    logic [RW-1:0] l;
    int            ws;
    ws = slot_w(p);
    t  = '0;
    for (int i = 0; i < NL; i++) begin
      if (i < lanes(p)) begin
        l = (v >> (i * ws)) & lane_mask(ws);
        if (l[ws-1]) l = l | ~lane_mask(ws);
        t = t + l;
      end
    end
    return t;
  endfunction : lane_total

  // ----------------------------------------------------------------------------
  // configuration and status
  // ----------------------------------------------------------------------------
  logic [31:0]      ctrl_r;      // control register
  logic             sat_hit_r;   // sticky: an overflow was seen with saturation on
  logic             ack_r;       // bus answer
  logic [31:0]      dat_r;       // bus read data
  logic             wb_hit;      // new bus request
  logic [$clog2(FIFO_DEPTH):0] f_cnt;
  logic [3:0]       cnt4;
  logic [31:0]      status_v;
  cdms_mode_t       mode;
  cdms_part_t       part;

  assign mode   = cdms_mode_t'(ctrl_r[`CDMS_F_MODE +: 2]);
  assign part   = cdms_part_t'(ctrl_r[`CDMS_F_PART +: 2]);
  assign wb_hit = wb_cyc & wb_stb & ~ack_r;
  assign cnt4   = 4'(f_cnt);
  assign wb_ack = ack_r;
  assign wb_dat_r = dat_r;

  // status word assembly
  always_comb begin
    status_v = '0;
    status_v[`CDMS_F_CNT +: 4]  = cnt4;
    status_v[`CDMS_F_FULL]      = f_cnt == ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH);
    status_v[`CDMS_F_EMPTY]     = f_cnt == '0;
    status_v[`CDMS_F_SAT_HIT]   = sat_hit_r;
  end

  // bus answer one cycle after the request, dropped the next
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ack_r <= 1'b0;
    else if (clk_en) ack_r <= wb_hit;
  end

  // control write with byte lanes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `CDMS_CTRL_RESET;
    end else if (clk_en && wb_hit && wb_we && wb_adr == `CDMS_OFS_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel[i]) ctrl_r[8*i +: 8] <= wb_dat_w[8*i +: 8] & 8'(`CDMS_CTRL_MASK >> (8*i));
      end
    end
  end

  // read data register; unmapped offsets read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dat_r <= '0;
    end else if (clk_en && wb_hit) begin
      unique case (wb_adr)
        `CDMS_OFS_CTRL:   dat_r <= ctrl_r;
        `CDMS_OFS_STATUS: dat_r <= status_v;
        default:          dat_r <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // datapath stages
  // ----------------------------------------------------------------------------
  logic           adv;                       // whole pipe moves
  logic           f_in_ready;                // fifo has room
  logic           f_out_valid;               // fifo has a word
  logic           s0_vr, s0_ldr;             // input register
  logic [AW-1:0]  s0_ar, s0_br, s0_cr;
  logic [RW-1:0]  s0_dr;
  logic           s0_v, s0_ld;               // input stage view
  logic [AW-1:0]  s0_a, s0_b, s0_c;
  logic [RW-1:0]  s0_d;
  logic [RW-1:0]  p1;                        // lane products
  logic           s1_vr, s1_ldr;             // pipeline register
  logic [RW-1:0]  s1_pr, s1_dr;
  logic           s1_v, s1_ld;               // product stage view
  logic [RW-1:0]  s1_p, s1_d;
  logic [RW-1:0]  acc_r, acc_nxt;            // accumulator
  logic [RW-1:0]  res;                       // combined result
  logic           res_ov;                    // overflow seen with saturation on
  logic           s2_vr;                     // output register
  logic [RW-1:0]  s2_qr;
  logic           o_v;                       // result stage view
  logic [RW-1:0]  o_q;

  assign adv      = clk_en & f_in_ready & ~rst;
  assign in_ready = adv;
  assign out_valid = clk_en & f_out_valid;

  // bypass muxes for the optional stages
  assign s0_v  = ctrl_r[`CDMS_F_IN_REG] ? s0_vr  : in_valid;
  assign s0_ld = ctrl_r[`CDMS_F_IN_REG] ? s0_ldr : in_acc_load;
  assign s0_a  = ctrl_r[`CDMS_F_IN_REG] ? s0_ar  : in_a;
  assign s0_b  = ctrl_r[`CDMS_F_IN_REG] ? s0_br  : in_b;
  assign s0_c  = ctrl_r[`CDMS_F_IN_REG] ? s0_cr  : in_c;
  assign s0_d  = ctrl_r[`CDMS_F_IN_REG] ? s0_dr  : in_d;
  assign s1_v  = ctrl_r[`CDMS_F_PIPE_REG] ? s1_vr  : s0_v;
  assign s1_ld = ctrl_r[`CDMS_F_PIPE_REG] ? s1_ldr : s0_ld;
  assign s1_p  = ctrl_r[`CDMS_F_PIPE_REG] ? s1_pr  : p1;
  assign s1_d  = ctrl_r[`CDMS_F_PIPE_REG] ? s1_dr  : s0_d;
  assign o_v   = ctrl_r[`CDMS_F_OUT_REG] ? s2_vr : s1_v;
  assign o_q   = ctrl_r[`CDMS_F_OUT_REG] ? s2_qr : res;

  // multiplier array, with or without pre-adder
  assign p1 = products(s0_a, s0_b, s0_c, part, ctrl_r[`CDMS_F_SIGN_A],
                       ctrl_r[`CDMS_F_SIGN_B], ctrl_r[`CDMS_F_PREADD]);

  // operand registers; sync reset and enable gate every stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {s0_vr, s0_ldr, s0_ar, s0_br, s0_cr, s0_dr} <= '0;
    end else if (clk_en && rst) begin
      {s0_vr, s0_ldr, s0_ar, s0_br, s0_cr, s0_dr} <= '0;
    end else if (adv) begin
      {s0_vr, s0_ldr, s0_ar, s0_br, s0_cr, s0_dr} <= {in_valid, in_acc_load,
                                                      in_a, in_b, in_c, in_d};
    end
  end

  // internal pipeline register after the multiplier
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {s1_vr, s1_ldr, s1_pr, s1_dr} <= '0;
    end else if (clk_en && rst) begin
      {s1_vr, s1_ldr, s1_pr, s1_dr} <= '0;
    end else if (adv) begin
      {s1_vr, s1_ldr, s1_pr, s1_dr} <= {s0_v, s0_ld, p1, s0_d};
    end
  end

  // post-multiply combine: add/subtract, accumulate, sum, round, clamp
  always_comb begin
    logic [RW+7:0] t;
    logic [RW+7:0] r;
    logic [7:0]    ov;
    cdms_part_t    pe;
    t  = '0;
    ov = '0;
    r  = '0;
    pe = part;
    acc_nxt = acc_r;
    unique case (mode)
      mode_multiply: t = {8'h00, s1_p};
      mode_multiply_accumulate: begin
        t = s1_ld ? {8'h00, s1_p}
                  : lane_add(acc_r, s1_p, ctrl_r[`CDMS_F_SUB], part);
        acc_nxt = ctrl_r[`CDMS_F_SAT] ? saturate(t[RW-1:0], t[RW+7:RW], part)
                                      : t[RW-1:0];
      end
      mode_multiply_add_subtract: t = lane_add(s1_d, s1_p, ctrl_r[`CDMS_F_SUB], part);
      mode_multiply_add_subtract_sum: begin
        t  = lane_add(s1_d, s1_p, ctrl_r[`CDMS_F_SUB], part);
        ov = t[RW+7:RW];
        t  = {8'h00, lane_total(ctrl_r[`CDMS_F_SAT] ? saturate(t[RW-1:0], ov, part)
                                                    : t[RW-1:0], part)};
        pe = mul_36_by_36;
      end
    endcase
    if (mode == mode_multiply_accumulate) t = {t[RW+7:RW], acc_nxt};
    ov = ov | t[RW+7:RW];
    r  = {8'h00, t[RW-1:0]};
    if (ctrl_r[`CDMS_F_RND]) begin
      r  = lane_add(t[RW-1:0], rnd_bits(ctrl_r[`CDMS_F_RSH +: 5], 1'b1, pe), 1'b0, pe);
      ov = ov | r[RW+7:RW];
    end
    res = ctrl_r[`CDMS_F_SAT] ? saturate(r[RW-1:0], r[RW+7:RW], pe) : r[RW-1:0];
    if (ctrl_r[`CDMS_F_RND]) res = res & ~rnd_bits(ctrl_r[`CDMS_F_RSH +: 5], 1'b0, pe);
    res_ov = ctrl_r[`CDMS_F_SAT] & (ov != '0);
  end

  // running accumulator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) acc_r <= '0;
    else if (clk_en && rst) acc_r <= '0;
    else if (adv && s1_v && mode == mode_multiply_accumulate) acc_r <= acc_nxt;
  end

  // product output register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) {s2_vr, s2_qr} <= '0;
    else if (clk_en && rst) {s2_vr, s2_qr} <= '0;
    else if (adv) {s2_vr, s2_qr} <= {s1_v, res};
  end

  // sticky clamp flag; a new clamp wins over a clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sat_hit_r <= 1'b0;
    end else if (clk_en) begin
      if (adv && s1_v && res_ov) sat_hit_r <= 1'b1;
      else if (wb_hit && wb_we && wb_adr == `CDMS_OFS_STATUS && wb_sel[2] &&
               wb_dat_w[`CDMS_F_SAT_HIT]) sat_hit_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------------------
  cdms_fifo #(
    .WIDTH (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .clk_en    (clk_en),
    .clr       (rst),
    .in_valid  (o_v),
    .in_ready  (f_in_ready),
    .in_data   (o_q),
    .out_valid (f_out_valid),
    .out_ready (out_ready),
    .out_data  (out_data),
    .count     (f_cnt)
  );

endmodule : cdms_slice

// file: verif/cdms_slice_props.sv
// port checker for the multiplier slice
module cdms_slice_props (
  // clock and resets
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         clk_en,
  input wire logic         rst,
  // register bus
  input wire logic         wb_cyc,
  input wire logic         wb_stb,
  input wire logic         wb_ack,
  input wire logic [31:0]  wb_dat_r,
  // streams
  input wire logic         in_ready,
  input wire logic         out_valid,
  input wire logic         out_ready,
  input wire logic [159:0] out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // --------
  // register bus answers
  // --------
  AST_ACK_ANSWER:
    assert property (wb_cyc && wb_stb && !wb_ack && clk_en |=> wb_ack)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE:
    assert property (wb_ack && clk_en |=> !wb_ack) else $error("ack longer than a cycle");
  AST_ACK_CAUSE:
    assert property ($rose(wb_ack) |-> $past(wb_stb)) else $error("ack without request");
  // --------
  // reset and freeze
  // --------
  AST_RDY_RST:
    assert property (rst |-> !in_ready) else $error("ready during sync reset");
  AST_RST_EMPTY:
    assert property (rst && clk_en |=> !out_valid) else $error("results kept over reset");
  AST_FREEZE_FLAGS:
    assert property (!clk_en |-> !in_ready && !out_valid) else $error("handshake while frozen");
  AST_FREEZE_HOLD:
    assert property (!clk_en |=> $stable(out_data) && $stable(wb_dat_r) && $stable(wb_ack))
    else $error("state moved while frozen");
  AST_HEAD_HOLD:
    assert property (out_valid && !out_ready && !rst |=> $stable(out_data))
    else $error("head word changed before pop");
  // main scenarios
  C_POP: cover property (out_valid && out_ready);
  C_FULL: cover property (out_valid && !out_ready && !in_ready && clk_en);
  C_FREEZE: cover property (!clk_en && wb_cyc);
  C_SRST: cover property (rst && clk_en);
endmodule : cdms_slice_props

bind cdms_slice cdms_slice_props cdms_slice_props_inst (.clk, .rstn, .clk_en, .rst, .wb_cyc,
  .wb_stb, .wb_ack, .wb_dat_r, .in_ready, .out_valid, .out_ready, .out_data);

// file: verif/cdms_sink.sv
// result consumer standing in for the fabric beyond the slice
module cdms_sink (
  // clock and result stream
  input  wire logic         clk,
  input  wire logic         out_valid,
  input  wire logic [159:0] out_data,
  // 0 always ready, 1 random stalls, 2 stalled
  input  wire logic [1:0]   mode,
  output      logic         out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [159:0] got [$];  // words taken, in order
  initial out_ready = 1'b0;
  // take on an accepted edge, then choose the next ready level
  always @(posedge clk) begin
    if (out_valid && out_ready) got.push_back(out_data);
    case (mode)
      2'h0: out_ready <= 1'b1;
      2'h1: out_ready <= ($urandom % 3) != 0;
      default: out_ready <= 1'b0;
    endcase
  end
endmodule : cdms_sink

// file: verif/tb_top.sv
// self-checking bench for the multiplier slice
`include "cdms_params.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // signals
  // --------
  logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, rst = 1'b0, jit = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, in_valid = 1'b0, in_ready;
  logic in_acc_load = 1'b0, out_valid, out_ready;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q, cfg;
  logic [71:0] in_a = 72'h0, in_b = 72'h0, in_c = 72'h0, ra, rb, rc;
  logic [159:0] in_d = 160'h0, out_data, rd, acc;
  logic [1:0] smode = 2'h0;
  logic [159:0] exp_q [$];  // expected words in order
  int n_fail = 0, check_count = 0, k, p, m;
  cdms_slice #(.FIFO_DEPTH(8)) cdms_slice_inst (.clk, .rstn, .clk_en, .rst, .wb_cyc, .wb_stb,
    .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .in_valid, .in_ready, .in_a,
    .in_b, .in_c, .in_d, .in_acc_load, .out_valid, .out_ready, .out_data);
  cdms_sink cdms_sink_inst (.clk, .out_valid, .out_data, .mode(smode), .out_ready);
  initial forever #2 clk = ~clk;
  // random freeze when enabled
  always @(posedge clk) clk_en <= !jit || ($urandom % 8 != 0);
  // --------
  // expectation
  // --------
  function automatic logic signed [80:0] ext(logic [80:0] v, int w, bit s);
    logic signed [80:0] t;
    t = v & ((81'd1 << w) - 1);
    if (s && t[w-1]) t = t - (81'sd1 << w);
    return t;
  endfunction : ext
  // per-lane product, optional preadd, then optional d +/- it
  function automatic logic [159:0] expect_w(logic [71:0] a, b, c, logic [159:0] d, int p,
      bit sa, sb, pre, ad, sub);
    int wa, wb, sl;
    logic signed [159:0] x, y, r;
    logic [159:0] mk, o;
    wa = (p == 0) ? 36 : (p == 3) ? 9 : 18;
    wb = (p < 2) ? 36 : wa;
    sl = 160 >> p;
    mk = (160'd1 << sl) - 1;
    o = '0;
    for (int i = 0; i < (1 << p); i++) begin
      x = ext(a >> (wa * i), wa, sa);
      y = ext(b >> (wb * i), wb, sb);
      if (pre) begin
        x = x + ext(b >> (wa * i), wa, sa);
        y = ext(c >> (wb * i), wb, sb);
      end
      r = x * y;
      if (ad) r = (d >> (sl * i)) + (sub ? -r : r);
      o = o | ((r & mk) << (sl * i));
    end
    return o;
  endfunction : expect_w
  // --------
  // bus, stream and closing tasks
  // --------
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic wb(bit we, logic [3:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
    int t = 0;
    do @(posedge clk); while (wb_ack !== 1'b0 && ++t < 99);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= d;
    do @(posedge clk); while (wb_ack !== 1'b1 && ++t < 99);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (t >= 99) n_fail++;
    if (t >= 99) end_sim();
  endtask : wb
  task automatic rnd();
    ra = 72'({$urandom, $urandom, $urandom});
    rb = 72'({$urandom, $urandom, $urandom});
    rc = 72'({$urandom, $urandom, $urandom});
    rd = {$urandom, $urandom, $urandom, $urandom, $urandom};
  endtask : rnd
  task automatic snd(logic [159:0] e, bit ld = 1'b0);
    int t = 0;
    @(posedge clk);
    in_valid <= 1'b1;
    in_a <= ra;
    in_b <= rb;
    in_c <= rc;
    in_d <= rd;
    in_acc_load <= ld;
    do @(posedge clk); while (in_ready !== 1'b1 && ++t < 99);
    in_valid <= 1'b0;
    exp_q.push_back(e);
    if (t >= 99) n_fail++;
    if (t >= 99) end_sim();
  endtask : snd
  task automatic drain();
    int t = 0;
    while (cdms_sink_inst.got.size() < exp_q.size() && t++ < 999) @(posedge clk);
    foreach (exp_q[i]) `CHK("result", exp_q[i], cdms_sink_inst.got[i])
    if (t > 999) end_sim();
    exp_q = {};
    cdms_sink_inst.got = {};
  endtask : drain
  // --------
  // main sequence
  // --------
  initial begin
    k = $urandom(34);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    wb(0, `CDMS_OFS_CTRL, 0);
    `CHK("ctrl reset", `CDMS_CTRL_RESET, q)
    wb(1, `CDMS_OFS_CTRL, '1);
    wb(1, `CDMS_OFS_CTRL, 32'h0, 4'h1);
    wb(0, `CDMS_OFS_CTRL, 0);
    `CHK("ctrl mask", `CDMS_CTRL_MASK & 32'hffff_ff00, q)
    wb(1, 4'hc, '1);
    wb(0, 4'hc, 0);
    `CHK("unmapped", 32'h0, q)
    // each optional register stage adds one cycle
    for (int r = 0; r < 8; r++) begin
      wb(1, `CDMS_OFS_CTRL, 32'(r << 6));
      rnd();
      snd(expect_w(ra, rb, rc, rd, 0, 0, 0, 0, 0, 0));
      for (k = 0; out_valid !== 1'b1 && k < 20; k++) @(posedge clk);
      `CHK("latency", 1 + $countones(r), k)
      drain();
    end
    // stalled consumer: fill until refused, then sync reset
    smode <= 2'h2;
    wb(1, `CDMS_OFS_CTRL, 32'h0);
    @(posedge clk);
    in_valid <= 1'b1;
    k = 0;
    repeat (20) @(posedge clk) k += (in_ready === 1'b1);
    in_valid <= 1'b0;
    `CHK("fifo fill", 8, k)
    wb(0, `CDMS_OFS_STATUS, 0);
    `CHK("status full", 32'h0000_0108, q)
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    wb(0, `CDMS_OFS_STATUS, 0);
    `CHK("status empty", 32'h0000_0200, q)
    // random partitions, signs, preadd, modes, stages and freezes
    jit <= 1'b1;
    smode <= 2'h1;
    repeat (24) begin
      p = $urandom % 4;
      m = $urandom % 3;
      cfg = ($urandom & 32'h0000_06f0) | 32'(m) | 32'(p << 2);
      if (p == 1) cfg[9] = 1'b0;
      wb(1, `CDMS_OFS_CTRL, cfg);
      for (int j = 0; j < 3; j++) begin
        rnd();
        acc = expect_w(ra, rb, rc, (m == 1) ? acc : rd, p, cfg[4], cfg[5], cfg[9],
                       m == 2 || (m == 1 && j > 0), cfg[10]);
        snd(acc, m == 1 && j == 0);
      end
      drain();
    end
    end_sim();
  end
endmodule : tb_top
